// ### design/plsm_port_led_mux.sv
// port led stream mux: captures two serial led streams, buffers
// finished frames and drives 64 tri-colour port leds.
// assumes stream pins are asynchronous to i_clk and slow next to
// it (several core cycles per stream bit).
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "plsm_map.svh"

// How it works
// - twelve-bit port slot holds four lane fields
// - lane field is blue-green-red, passed unchanged
// - bit 0 arrives first, bit 191 last
// - drive 64 tri-colour leds, 192 bits
// - cage has four leds, a to d
// - button picks top or bottom port lanes
// - bits 2:0 select direct, twelve-bit or test
// - bit 0 holds both streams cleared
// - bit 1 enables both streams
// - bit 3 runs a walk pattern
// - bits 5:4 pick single or all-led test
// - bit 6 blinks test leds
// - bit 7 turns on port led test mode
module plsm_port_led_mux
    import plsm_pkg::*;
#(
    parameter int BLINK_CYCLES = `PLSM_BLINK_MS * `PLSM_CLK_KHZ
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic [7:0]   i_addr,
    input  wire logic [7:0]   i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic      [7:0]   o_rdata,
    input  wire logic [1:0]   i_stream_clk,
    input  wire logic [1:0]   i_stream_data,
    output logic              o_stream_ready,
    input  wire logic         i_led_sel,
    input  wire logic         i_led_ready,
    output logic              o_led_valid,
    output logic      [191:0] o_led
);

    // ==========================================================
    // parameter check
    localparam int NB = `PLSM_FRAME_BITS;
    localparam int BW = $clog2(BLINK_CYCLES + 1);
    generate
        if (BLINK_CYCLES < 1) begin : g_bad_blink
            $error("blink count must be at least one");
        end
    endgenerate

    // ==========================================================
    // registers
    logic [7:0]   ctrl_q;      // control register
    logic [7:0]   pat_q;       // test led number and colour
    logic [2:0][1:0] clk_s_q;  // link clock sync, stages 1..3
    logic [2:0][1:0] dat_s_q;  // link data sync
    logic [1:0]   clk_st_q;    // agreed link clock level
    logic         sel_s_q0;    // button sync stage 1
    logic         sel_s_q1;    // button sync stage 2
    logic         sel_s_q2;    // button sync stage 3
    logic         sel_q;       // agreed button level
    logic [NB-1:0] sh_q [2];   // per-stream shift chains
    logic [7:0]   cnt_q [2];   // bits taken in this frame
    logic [1:0]   pend_q;      // frame waits for the buffer
    plsm_frame_type buf_q [2]; // two-entry frame buffer
    logic         wp_q;        // buffer write slot
    logic         rp_q;        // buffer read slot
    logic [1:0]   lvl_q;       // buffer fill level
    logic [NB-1:0] frm_q [2];  // last shown frame per stream
    logic [7:0]   drop_q;      // frames lost to a full buffer
    logic [BW-1:0] tick_cnt_q; // blink and walk divider
    logic         blink_q;     // blink phase
    logic [5:0]   walk_q;      // walking led position
    logic [191:0] led_q;       // driven led bits
    logic         led_v_q;     // new led image pending
    logic         pop_q;       // frame popped, image lands next

    // ==========================================================
    // control decode
    wire clr   = ctrl_q[`PLSM_CTRL_CLR];
    wire en    = ctrl_q[`PLSM_CTRL_EN];
    wire fmt   = ctrl_q[`PLSM_CTRL_FMT];
    wire walk  = ctrl_q[`PLSM_CTRL_WALK];
    wire blink = ctrl_q[`PLSM_CTRL_BLINK];
    wire tmode = ctrl_q[`PLSM_CTRL_TEST];
    wire [1:0] tsel = ctrl_q[`PLSM_CTRL_TSEL_HI:`PLSM_CTRL_TSEL_LO];
    // with bit 7 clear, 110 gives twelve-bit, 010 direct, anything else test logic
    wire       run_ok = en & ~clr & ~tmode;
    wire plsm_src_type src = !run_ok ? PLSM_SRC_TEST :
                              fmt    ? PLSM_SRC_TWELVE :
                                       PLSM_SRC_DIRECT;

    wire wr_ctrl = i_wr & (i_addr == `PLSM_OFS_CTRL);
    wire wr_pat  = i_wr & (i_addr == `PLSM_OFS_PATTERN);

    // ==========================================================
    // register writes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= `PLSM_CTRL_RESET;  // test on, blink on, tsel 10
            pat_q  <= `PLSM_PATTERN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= i_wdata;
            end
            if (wr_pat) begin
                pat_q <= i_wdata;
            end
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    wire [7:0] status = {drop_q[3:0], pend_q, lvl_q};
    wire [7:0] rd_mux = (i_addr == `PLSM_OFS_CTRL)    ? ctrl_q :
                        (i_addr == `PLSM_OFS_PATTERN) ? pat_q  :
                        (i_addr == `PLSM_OFS_STATUS)  ? status :
                                                        8'h00;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    // ==========================================================
    // pin synchronisers, three stages; agree on stages 2 and 3
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            clk_s_q  <= '0;
            dat_s_q  <= '0;
            sel_s_q0 <= 1'b0;
            sel_s_q1 <= 1'b0;
            sel_s_q2 <= 1'b0;
        end else begin
            clk_s_q  <= {clk_s_q[1:0], i_stream_clk};
            dat_s_q  <= {dat_s_q[1:0], i_stream_data};
            sel_s_q0 <= i_led_sel;
            sel_s_q1 <= sel_s_q0;
            sel_s_q2 <= sel_s_q1;
        end
    end

    wire [1:0] clk_agree = ~(clk_s_q[1] ^ clk_s_q[2]);
    wire [1:0] clk_rise  = clk_agree & clk_s_q[2] & ~clk_st_q;
    wire       sel_agree = (sel_s_q1 == sel_s_q2);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            clk_st_q <= 2'b00;
            sel_q    <= 1'b0;
        end else begin
            clk_st_q <= (clk_st_q & ~clk_agree) | (clk_s_q[2] & clk_agree);
            sel_q    <= sel_agree ? sel_s_q2 : sel_q;
        end
    end

    // ==========================================================
    // frame capture, one bit per agreed rising stream edge
    wire [1:0] push_ok;  // frame of stream s enters the buffer
    wire       space = (lvl_q != 2'd2);
    assign push_ok[0] = pend_q[0] & space;
    assign push_ok[1] = pend_q[1] & space & ~pend_q[0];
    assign o_stream_ready = space;  // low stalls the source

    // both streams in one process: pend_q has a single writer
    wire [1:0] take = clk_rise & {2{en & ~clr}};
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int s = 0; s < 2; s++) begin
                sh_q[s]  <= '0;
                cnt_q[s] <= 8'h00;
            end
            pend_q <= 2'b00;
        end else begin
            for (int s = 0; s < 2; s++) begin
                if (clr) begin
                    // held cleared while the clear bit is set
                    sh_q[s]   <= '0;
                    cnt_q[s]  <= 8'h00;
                    pend_q[s] <= 1'b0;
                end else if (take[s]) begin
                    // shift right: first bit ends at position 0
                    sh_q[s] <= {dat_s_q[2][s], sh_q[s][NB-1:1]};
                    // a new bit overwrites a frame still waiting
                    pend_q[s] <= (cnt_q[s] == 8'(NB - 1));
                    cnt_q[s]  <= (cnt_q[s] == 8'(NB - 1)) ? 8'h00
                                                         : cnt_q[s] + 8'h01;
                end else if (push_ok[s]) begin
                    pend_q[s] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // two-entry buffer between capture and led image
    wire push = |push_ok;
    // one pop in flight at a time, so no image goes unoffered
    wire pop  = (lvl_q != 2'd0) & ~pop_q & ~clr &
                (~led_v_q | i_led_ready);
    wire plsm_frame_type push_frm =
        push_ok[0] ? plsm_frame_type'{1'b0, sh_q[0]}
                   : plsm_frame_type'{1'b1, sh_q[1]};
    wire plsm_frame_type pop_frm  = buf_q[rp_q];

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wp_q   <= 1'b0;
            rp_q   <= 1'b0;
            lvl_q  <= 2'd0;
            drop_q <= 8'h00;
        end else if (clr) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            lvl_q <= 2'd0;
        end else begin
            wp_q  <= wp_q ^ push;
            rp_q  <= rp_q ^ pop;
            lvl_q <= lvl_q + {1'b0, push} - {1'b0, pop};
            if (|(clk_rise & pend_q) & ~space & en) begin
                drop_q <= drop_q + 8'h01;
            end
        end
    end

    // storage has no reset; level guards every read
    always_ff @(posedge i_clk) begin
        if (push) begin
            buf_q[wp_q] <= push_frm;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            frm_q[0] <= '0;
            frm_q[1] <= '0;
        end else if (clr) begin
            frm_q[0] <= '0;
            frm_q[1] <= '0;
        end else if (pop) begin
            frm_q[pop_frm.stream] <= pop_frm.bits;
        end
    end

    // ==========================================================
    // blink and walk time base, one-cycle tick
    wire tick = (tick_cnt_q == BW'(BLINK_CYCLES - 1));
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt_q <= '0;
            blink_q    <= 1'b0;
            walk_q     <= 6'd0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + BW'(1);
            if (tick) begin
                blink_q <= ~blink_q;
                walk_q  <= walk ? walk_q + 6'd1 : 6'd0;
            end
        end
    end

    // ==========================================================
    // led image builders
    // one stream of twelve-bit slots: 16 ports, 8 cages, 96 bits;
    // lane fields pass as blue-green-red unchanged
    function automatic logic [95:0] cage_map(input logic [NB-1:0] f,
                                             input logic top);
        logic [95:0] o;
        o = '0;
        for (int c = 0; c < 8; c++) begin
            // even slot bottom port, odd slot top port
            o[c*12 +: 12] = top ? f[c*24+12 +: 12]
                                : f[c*24 +: 12];
        end
        return o;
    endfunction : cage_map

    // test image: single, all or walking led in pattern colour
    function automatic logic [191:0] test_map(input logic [1:0] ts,
                                              input logic       wk,
                                              input logic [5:0] wpos,
                                              input logic [7:0] pat);
        logic [191:0] o;
        logic [5:0]   base;
        o    = '0;
        base = {ts[0], 5'd0};  // stream 1 covers leds 32..63
        for (int l = 0; l < 64; l++) begin
            if (wk) begin
                if (6'(l) == wpos) o[l*3 +: 3] = pat[7:5];
            end else if (ts[1]) begin
                // int compare: a 6-bit sum would wrap at led 64
                if (l >= int'(base) && l < int'(base) + 32) begin
                    o[l*3 +: 3] = pat[7:5];
                end
            end else if (6'(l) == base + {1'b0, pat[4:0]}) begin
                o[l*3 +: 3] = pat[7:5];
            end
        end
        return o;
    endfunction : test_map

    // ==========================================================
    // source selection
    wire [191:0] img_direct = frm_q[0];
    wire [191:0] img_twelve = {cage_map(frm_q[1], sel_q),
                               cage_map(frm_q[0], sel_q)};
    wire [191:0] img_test   = test_map(tsel, walk, walk_q, pat_q);
    wire         dark       = blink & blink_q;
    wire [191:0] img_d      =
        (src == PLSM_SRC_DIRECT) ? img_direct :
        (src == PLSM_SRC_TWELVE) ? img_twelve :
        (dark ? 192'd0 : img_test);

    // ==========================================================
    // output image, refreshed every cycle, valid after each frame
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            led_q   <= '0;
            led_v_q <= 1'b0;
            pop_q   <= 1'b0;
        end else begin
            led_q   <= img_d;
            pop_q   <= pop;
            // valid rises with the image built from the new frame
            led_v_q <= pop_q | (led_v_q & ~i_led_ready);
        end
    end

    assign o_led       = led_q;
    assign o_led_valid = led_v_q;

endmodule : plsm_port_led_mux

// ### pkg/plsm_map.svh
// constants for the port led stream mux: offsets, field positions,
// reset values and timing figures.
// assumes a 10 MHz core clock and an 8-bit register port.
`ifndef PLSM_MAP_SVH
`define PLSM_MAP_SVH

// ==========================================================
// register offsets
`define PLSM_OFS_CTRL      8'h3c
`define PLSM_OFS_PATTERN   8'h3d
`define PLSM_OFS_STATUS    8'h3e

// ==========================================================
// control register fields
`define PLSM_CTRL_CLR      0
`define PLSM_CTRL_EN       1
`define PLSM_CTRL_FMT      2
`define PLSM_CTRL_WALK     3
`define PLSM_CTRL_TSEL_LO  4
`define PLSM_CTRL_TSEL_HI  5
`define PLSM_CTRL_BLINK    6
`define PLSM_CTRL_TEST     7
`define PLSM_CTRL_RESET    8'he0
`define PLSM_PATTERN_RESET 8'h00

// pattern register fields: led number [4:0], colour [7:5]
`define PLSM_PAT_NUM_HI    4
`define PLSM_PAT_COL_LO    5

// ==========================================================
// stream geometry and timing
`define PLSM_FRAME_BITS    192
`define PLSM_CLK_KHZ       10_000
`define PLSM_BLINK_MS      250

`endif

// ### pkg/plsm_pkg.sv
// types for the port led stream mux.
// assumes plsm_map.svh supplies the numeric constants.
package plsm_pkg;

    // ==========================================================
    // display source chosen from control bits 2:0 and test bit 7
    typedef enum logic [1:0] {
        PLSM_SRC_TEST   = 2'b00,
        PLSM_SRC_DIRECT = 2'b01,
        PLSM_SRC_TWELVE = 2'b10
    } plsm_src_type;

    // one finished frame from either stream
    typedef struct packed {
        logic         stream;  // 0 or 1
        logic [191:0] bits;    // bit 0 arrived first
    } plsm_frame_type;

    // link pins of one stream after synchronising
    typedef struct packed {
        logic clk;
        logic data;
    } plsm_link_type;

endpackage : plsm_pkg

// ### sim/plsm_port_led_mux_properties.sv
// checker for the port led stream mux, bound to the top ports.
// assumes registers change only through the strobe port.
`timescale 1ns/1ps
module plsm_port_led_mux_properties #(
    parameter int BLINK_CYCLES = 8
) (
    input wire logic         i_clk,
    input wire logic         i_resetn,
    input wire logic [7:0]   i_addr,
    input wire logic [7:0]   i_wdata,
    input wire logic         i_wr,
    input wire logic         i_rd,
    input wire logic [7:0]   o_rdata,
    input wire logic [1:0]   i_stream_clk,
    input wire logic [1:0]   i_stream_data,
    input wire logic         o_stream_ready,
    input wire logic         i_led_sel,
    input wire logic         i_led_ready,
    input wire logic         o_led_valid,
    input wire logic [191:0] o_led
);
    // ==========================================================
    // shadow copies of the writable registers
    logic [7:0] ctrl_q;  // control as last written
    logic [7:0] pat_q;   // pattern as last written
    // consumer stalls and no write can move the mode
    wire logic  stalled = o_led_valid && !i_led_ready && !i_wr;

    // shadows follow the bus, never the design
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= 8'he0;
            pat_q  <= 8'h00;
        end else if (i_wr && i_addr == 8'h3c) begin
            ctrl_q <= i_wdata;
        end else if (i_wr && i_addr == 8'h3d) begin
            pat_q <= i_wdata;
        end
    end

    // ==========================================================
    // properties
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence rd_at(logic [7:0] a);
        i_rd && i_addr == a;
    endsequence
    // three quiet cycles let the registered image catch up
    sequence quiet3;
        !i_wr [*3];
    endsequence

    a_ctrl_read_back:
        assert property (rd_at(8'h3c) |=> o_rdata == ctrl_q)
        else $error("control read data differs from last write");
    a_pat_read_back:
        assert property (rd_at(8'h3d) |=> o_rdata == pat_q)
        else $error("pattern read data differs from last write");
    a_rdata_after_read:
        assert property (o_rdata != 8'h00 |-> $past(i_rd))
        else $error("read data without a read strobe");
    a_unmapped_read_zero:
        assert property (i_rd && (i_addr < 8'h3c || i_addr > 8'h3e)
            |=> o_rdata == 8'h00)
        else $error("unmapped read returned data");
    a_clear_keeps_empty:
        assert property (ctrl_q[0] [*3]
            |-> o_stream_ready && !$rose(o_led_valid))
        else $error("frame taken while streams cleared");
    a_disabled_no_frame:
        assert property (!ctrl_q[1] [*3] |-> !$rose(o_led_valid))
        else $error("frame taken while streams disabled");
    a_valid_waits:
        assert property (stalled |=> o_led_valid)
        else $error("led valid dropped without ready");
    a_image_holds:
        assert property (stalled && ctrl_q == 8'h02 |=> $stable(o_led))
        else $error("led image moved during a stall");
    a_test_all_leds:
        assert property (quiet3 ##0 ctrl_q == 8'ha0
            |-> o_led == {96'h0, {32{pat_q[7:5]}}})
        else $error("all-led test image wrong");
endmodule : plsm_port_led_mux_properties

// ### sim/plsm_port_led_mux_test.sv
// self-checking bench for the port led stream mux.
// assumes the stream source model drives both stream inputs.
`timescale 1ns/1ps
module plsm_port_led_mux_test import plsm_pkg::*;;
    localparam int BLINK_CYCLES = 8;  // short tick keeps runs brief
    logic         i_clk;
    logic         i_resetn;
    logic [7:0]   i_addr;
    logic [7:0]   i_wdata;
    logic         i_wr;
    logic         i_rd;
    logic [7:0]   o_rdata;
    logic [1:0]   i_stream_clk;   // from the source model
    logic [1:0]   i_stream_data;  // from the source model
    logic         o_stream_ready;
    logic         i_led_sel;
    logic         i_led_ready;
    logic         o_led_valid;
    logic [191:0] o_led;
    int           fail_count;
    int           samples_checked;
    logic [191:0] f0;             // last stream 0 frame
    logic [191:0] f1;             // last stream 1 frame

    plsm_port_led_mux #(.BLINK_CYCLES(BLINK_CYCLES)) plsm_port_led_mux_inst (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_stream_clk(i_stream_clk), .i_stream_data(i_stream_data),
        .o_stream_ready(o_stream_ready), .i_led_sel(i_led_sel),
        .i_led_ready(i_led_ready), .o_led_valid(o_led_valid), .o_led(o_led)
    );
    plsm_stream_source plsm_stream_source_inst (
        .o_stream_clk(i_stream_clk), .o_stream_data(i_stream_data)
    );

    // ==========================================================
    // 10 MHz core clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // ==========================================================
    // shared helpers
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string name, input logic [191:0] exp,
                         input logic [191:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        check("read data", 192'(exp), 192'(o_rdata));
    endtask : rd
    // wait for a new image, compare, then acknowledge it
    task automatic take(input logic [191:0] exp);
        int n;
        for (n = 0; n < 60 && o_led_valid !== 1'b1; n++) begin
            settle(1);
        end
        if (n == 60) begin
            fail_count++;
            $display("unexpected led valid: expected 1 seen 0");
            stop_test();
        end else begin
            check("led image", exp, o_led);
            @(posedge i_clk);
            i_led_ready <= 1'b1;
            @(posedge i_clk);
            i_led_ready <= 1'b0;
        end
    endtask : take
    function automatic logic [191:0] make_frame(input int seed);
        logic [191:0] f;
        for (int i = 0; i < 64; i++) begin
            f[3*i +: 3] = 3'(i * 3 + seed);  // every code turns up
        end
        return f;
    endfunction : make_frame
    // cage c shows bottom slot 2c or top slot 2c+1 of its stream
    function automatic logic [191:0] twelve(input logic [191:0] a,
        input logic [191:0] b, input logic top);
        logic [191:0] e;
        for (int c = 0; c < 8; c++) begin
            e[12*c +: 12]      = a[24*c + (top ? 12 : 0) +: 12];
            e[96 + 12*c +: 12] = b[24*c + (top ? 12 : 0) +: 12];
        end
        return e;
    endfunction : twelve

    // ==========================================================
    // scenarios
    task automatic t_registers();
        rd(8'h3c, 8'he0);
        rd(8'h3d, 8'h00);
        rd(8'h3e, 8'h00);
        rd(8'h40, 8'h00);  // unmapped place
        wr(8'h3d, 8'ha5);
        rd(8'h3d, 8'ha5);
    endtask : t_registers
    task automatic t_test_leds();
        logic [191:0] exp [4];
        exp[0] = 192'(3'b001) << 15;
        exp[1] = 192'(3'b001) << 111;
        exp[2] = {96'h0, {32{3'b001}}};
        exp[3] = {{32{3'b001}}, 96'h0};
        wr(8'h3d, 8'h25);  // red, led 5
        for (int k = 0; k < 4; k++) begin
            wr(8'h3c, 8'h80 | 8'(k << 4));
            settle(4);
            check("test image", exp[k], o_led);
        end
    endtask : t_test_leds
    // blink and walk must both keep the image moving
    task automatic t_animation();
        int           moves;
        logic [191:0] last;
        for (int j = 0; j < 2; j++) begin
            wr(8'h3c, j == 0 ? 8'he0 : 8'h88);
            moves = 0;
            last  = o_led;
            repeat (40) begin
                settle(1);
                moves += int'(o_led !== last);
                last = o_led;
            end
            check("image moving", 192'(1), 192'(moves > 2));
        end
    endtask : t_animation
    task automatic t_direct();
        wr(8'h3c, 8'h02);
        f0 = make_frame(1);
        plsm_stream_source_inst.send(0, f0);
        take(f0);
    endtask : t_direct
    task automatic t_twelve();
        wr(8'h3c, 8'h06);
        f0 = make_frame(2);
        f0[23:12] = f0[11:0];  // full-rate pair repeats its slot
        plsm_stream_source_inst.send(0, f0);
        take(twelve(f0, 192'h0, 1'b0));
        f1 = make_frame(5);
        plsm_stream_source_inst.send(1, f1);
        take(twelve(f0, f1, 1'b0));
        @(posedge i_clk);
        i_led_sel <= 1'b1;
        settle(8);
        check("top lanes", twelve(f0, f1, 1'b1), o_led);
    endtask : t_twelve
    // stall the consumer until the buffer refuses, then drain
    task automatic t_buffer();
        wr(8'h3c, 8'h02);
        for (int n = 0; n < 4 && o_stream_ready === 1'b1; n++) begin
            f0 = make_frame(10 + n);
            plsm_stream_source_inst.send(0, f0);
            settle(10);
        end
        check("stream ready", 192'(0), 192'(o_stream_ready));
        rd(8'h3e, 8'h02);  // two frames held, none pending or lost
        @(posedge i_clk);
        i_led_ready <= 1'b1;
        settle(20);
        check("stream ready", 192'(1), 192'(o_stream_ready));
        check("drained image", f0, o_led);
    endtask : t_buffer
    task automatic t_clear();
        @(posedge i_clk);
        i_led_ready <= 1'b0;
        wr(8'h3c, 8'h03);
        plsm_stream_source_inst.send(0, make_frame(20));
        settle(10);
        check("valid in clear", 192'(0), 192'(o_led_valid));
        wr(8'h3c, 8'h02);
        settle(4);
        check("cleared image", 192'h0, o_led);
    endtask : t_clear

    initial begin
        fail_count      = 0;
        samples_checked = 0;
        i_resetn        = 1'b0;
        i_addr          = 8'h00;
        i_wdata         = 8'h00;
        i_wr            = 1'b0;
        i_rd            = 1'b0;
        i_led_sel       = 1'b0;
        i_led_ready     = 1'b0;
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_registers();
        t_test_leds();
        t_animation();
        t_direct();
        t_twelve();
        t_buffer();
        t_clear();
        stop_test();
    end
endmodule : plsm_port_led_mux_test

bind plsm_port_led_mux plsm_port_led_mux_properties #(
    .BLINK_CYCLES(BLINK_CYCLES)) plsm_port_led_mux_properties_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_stream_clk(i_stream_clk), .i_stream_data(i_stream_data),
    .o_stream_ready(o_stream_ready), .i_led_sel(i_led_sel),
    .i_led_ready(i_led_ready), .o_led_valid(o_led_valid), .o_led(o_led)
);

// ### sim/plsm_stream_source.sv
// model of the switch chip led stream source, one task per frame.
// assumes the bench calls send for one stream at a time.
`timescale 1ns/1ps
module plsm_stream_source (
    output logic [1:0] o_stream_clk,
    output logic [1:0] o_stream_data
);
    // ==========================================================
    // idle: clock stands low between frames
    initial begin
        o_stream_clk  = 2'b00;
        o_stream_data = 2'b00;
    end

    // 800 ns bit time, offset so edges fall between core clock edges
    task automatic send(input int idx, input logic [191:0] frame);
        #37;
        for (int b = 0; b < 192; b++) begin
            o_stream_data[idx] = frame[b];
            #400;
            o_stream_clk[idx] = 1'b1;
            #400;
            o_stream_clk[idx] = 1'b0;
        end
        // hold over: no pull, so show a stale-looking value
        o_stream_data[idx] = ~frame[191];
    endtask : send
endmodule : plsm_stream_source
